// File: rtl/peripheral_dma.sv
// Register interface and control of a receive/transmit peripheral DMA channel pair.
// Assumes an APB master, a peripheral holding ready levels, and a memory port that acks each move.
//
// Contract
// - Receive pointer, 32 bits, at 0x100
// - Receive count, 16 bits, low half
// - Transmit pointer, 32 bits, read/write
// - Transmit count; no transmit while zero
// - Receive next pointer for following buffer
// - Receive next count for following buffer
// - Transmit next pointer for following buffer
// - Transmit next count for following buffer
// - Receive enable works unless disable set
// - Receive disable bit turns requests off
// - Transmit enable bit turns requests on
// - Transmit disable bit turns requests off
// - Command write-only; status read-only, reset zero
// - Eight pointer/count registers reset to zero
// - Interface sits at offset 0x100 onward
// - Pointer advances one, two or four
// - Count decrements per transfer, stops at zero
// - At zero, load next, clear next count
// - Count register write clears end flag
`include "peripheral_dma_defines.svh"
`default_nettype none
module peripheral_dma
  import peripheral_dma_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output var  logic [31:0] o_prdata,
  output var  logic        o_pready,
  output var  logic        o_pslverr,
  input  wire logic [1:0]  i_transfer_size,
  input  wire logic        i_rx_ready,
  input  wire logic        i_tx_ready,
  output var  logic        o_mem_req,
  output var  logic        o_mem_write,
  output var  logic [31:0] o_mem_addr,
  input  wire logic        i_mem_done,
  output var  logic        o_rx_buffer_end_flag,
  output var  logic        o_tx_buffer_end_flag,
  output var  logic        o_rx_all_buffers_full_flag,
  output var  logic        o_tx_all_buffers_empty_flag
);

  // ==========================================================
  // Register state
  logic [31:0] rx_buffer_address, next_rx_buffer_address;
  logic [15:0] rx_transfers_left, next_rx_transfers_left;
  logic [31:0] tx_buffer_address, next_tx_buffer_address;
  logic [15:0] tx_transfers_left, next_tx_transfers_left;
  logic [31:0] rx_following_address, next_rx_following_address;
  logic [15:0] rx_following_length, next_rx_following_length;
  logic [31:0] tx_following_address, next_tx_following_address;
  logic [15:0] tx_following_length, next_tx_following_length;
  logic        rx_enabled, next_rx_enabled;
  logic        tx_enabled, next_tx_enabled;
  logic        rx_end, next_rx_end;
  logic        tx_end, next_tx_end;
  logic [31:0] prdata, next_prdata;
  logic        pready, next_pready;
  logic        pslverr, next_pslverr;
  move_state_e state, next_state;
  logic        mem_req, next_mem_req;
  logic        mem_write, next_mem_write;
  logic [31:0] mem_addr, next_mem_addr;

  logic        access;
  logic        wr;
  logic        commit;
  logic        known;
  logic [31:0] step;
  // Done strobes of the mover, seen by the channel registers
  logic        rx_done;
  logic        tx_done;
  logic        rx_last;
  logic        tx_last;

  // ==========================================================
  // Bus decode
  // Taking a request only while no answer is out keeps a held access from being taken twice
  assign access = i_psel && i_penable && !pready;
  assign wr     = access && i_pwrite;
  // A write lands at the completing edge, where the master sees pready high
  // Its response was already decided at the take edge
  assign commit = i_psel && i_penable && pready && i_pwrite;

  // ==========================================================
  // Bus response
  // Read data stands only with pready and is zero otherwise
  always_comb begin
    next_prdata  = `RESET_WORD;
    next_pready  = access;
    next_pslverr = 1'b0;
    known        = 1'b1;
    if (wr) begin
      case (i_paddr)
        `OFF_RX_BUFFER_ADDRESS,
        `OFF_RX_TRANSFERS_LEFT,
        `OFF_TX_BUFFER_ADDRESS,
        `OFF_TX_TRANSFERS_LEFT,
        `OFF_RX_FOLLOWING_ADDRESS,
        `OFF_RX_FOLLOWING_LENGTH,
        `OFF_TX_FOLLOWING_ADDRESS,
        `OFF_TX_FOLLOWING_LENGTH,
        `OFF_ENABLE_COMMAND:       known = 1'b1;
        // Status is read-only; a write to it is refused
        default:                   known = 1'b0;
      endcase
      next_pslverr = !known;
    end else if (access) begin
      case (i_paddr)
        `OFF_RX_BUFFER_ADDRESS:    next_prdata = rx_buffer_address;
        `OFF_RX_TRANSFERS_LEFT:    next_prdata = {16'h0000, rx_transfers_left};
        `OFF_TX_BUFFER_ADDRESS:    next_prdata = tx_buffer_address;
        `OFF_TX_TRANSFERS_LEFT:    next_prdata = {16'h0000, tx_transfers_left};
        `OFF_RX_FOLLOWING_ADDRESS: next_prdata = rx_following_address;
        `OFF_RX_FOLLOWING_LENGTH:  next_prdata = {16'h0000, rx_following_length};
        `OFF_TX_FOLLOWING_ADDRESS: next_prdata = tx_following_address;
        `OFF_TX_FOLLOWING_LENGTH:  next_prdata = {16'h0000, tx_following_length};
        `OFF_ENABLE_COMMAND:       next_prdata = `RESET_WORD;
        `OFF_ENABLE_STATE: begin
          next_prdata[`BIT_RX_ENABLE] = rx_enabled;
          next_prdata[`BIT_TX_ENABLE] = tx_enabled;
        end
        default: known = 1'b0;
      endcase
      next_pslverr = !known;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      prdata  <= `RESET_WORD;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================
  // Pointer step per item
  // Sizes two and three both move a word
  always_comb begin
    case (i_transfer_size)
      `SIZE_BYTE: step = `STEP_BYTE;
      `SIZE_HALF: step = `STEP_HALF;
      default:    step = `STEP_WORD;
    endcase
  end

  // ==========================================================
  // Data mover: receive served first, then transmit
  // Only one move is in flight, so pointers and counts never race each other
  always_comb begin
    next_state     = state;
    next_mem_req   = mem_req;
    next_mem_write = mem_write;
    next_mem_addr  = mem_addr;
    rx_done        = 1'b0;
    tx_done        = 1'b0;
    case (state)
      MOVE_IDLE: begin
        if (rx_enabled && i_rx_ready && rx_transfers_left != `RESET_COUNT) begin
          next_state     = MOVE_RX;
          next_mem_req   = 1'b1;
          next_mem_write = 1'b1;
          next_mem_addr  = rx_buffer_address;
        end else if (tx_enabled && i_tx_ready && tx_transfers_left != `RESET_COUNT) begin
          next_state     = MOVE_TX;
          next_mem_req   = 1'b1;
          next_mem_write = 1'b0;
          next_mem_addr  = tx_buffer_address;
        end
      end
      MOVE_RX: begin
        if (i_mem_done) begin
          next_state   = MOVE_IDLE;
          next_mem_req = 1'b0;
          rx_done      = 1'b1;
        end
      end
      MOVE_TX: begin
        if (i_mem_done) begin
          next_state   = MOVE_IDLE;
          next_mem_req = 1'b0;
          tx_done      = 1'b1;
        end
      end
      default: begin
        next_state   = MOVE_IDLE;
        next_mem_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state     <= MOVE_IDLE;
      mem_req   <= 1'b0;
      mem_write <= 1'b0;
      mem_addr  <= `RESET_WORD;
    end else begin
      state     <= next_state;
      mem_req   <= next_mem_req;
      mem_write <= next_mem_write;
      mem_addr  <= next_mem_addr;
    end
  end

  // ==========================================================
  // Channel registers
  // A move that empties the current buffer is its last one
  assign rx_last = rx_done && rx_transfers_left == `COUNT_ONE;
  assign tx_last = tx_done && tx_transfers_left == `COUNT_ONE;

  always_comb begin
    next_rx_buffer_address    = rx_buffer_address;
    next_rx_transfers_left    = rx_transfers_left;
    next_tx_buffer_address    = tx_buffer_address;
    next_tx_transfers_left    = tx_transfers_left;
    next_rx_following_address = rx_following_address;
    next_rx_following_length  = rx_following_length;
    next_tx_following_address = tx_following_address;
    next_tx_following_length  = tx_following_length;
    next_rx_enabled           = rx_enabled;
    next_tx_enabled           = tx_enabled;
    next_rx_end               = rx_end;
    next_tx_end               = tx_end;
    if (rx_done) begin
      if (rx_last) begin
        next_rx_buffer_address   = rx_following_address;
        next_rx_transfers_left   = rx_following_length;
        next_rx_following_length = `RESET_COUNT;
        // Requests stop when the next buffer is empty as well
        next_rx_enabled          = rx_following_length != `RESET_COUNT;
      end else begin
        next_rx_buffer_address = rx_buffer_address + step;
        next_rx_transfers_left = rx_transfers_left - `COUNT_ONE;
      end
    end
    if (tx_done) begin
      if (tx_last) begin
        next_tx_buffer_address   = tx_following_address;
        next_tx_transfers_left   = tx_following_length;
        next_tx_following_length = `RESET_COUNT;
        next_tx_enabled          = tx_following_length != `RESET_COUNT;
      end else begin
        next_tx_buffer_address = tx_buffer_address + step;
        next_tx_transfers_left = tx_transfers_left - `COUNT_ONE;
      end
    end

    // Software write wins over the mover's pointers, counts and enables in the same cycle (not the end flags): new values restart counting
    if (commit) begin
      case (i_paddr)
        `OFF_RX_BUFFER_ADDRESS:    next_rx_buffer_address = i_pwdata;
        `OFF_RX_TRANSFERS_LEFT: begin
          next_rx_transfers_left = i_pwdata[`COUNT_MSB:0];
          next_rx_end            = 1'b0;
        end
        `OFF_TX_BUFFER_ADDRESS:    next_tx_buffer_address = i_pwdata;
        `OFF_TX_TRANSFERS_LEFT: begin
          next_tx_transfers_left = i_pwdata[`COUNT_MSB:0];
          next_tx_end            = 1'b0;
        end
        `OFF_RX_FOLLOWING_ADDRESS: next_rx_following_address = i_pwdata;
        `OFF_RX_FOLLOWING_LENGTH: begin
          next_rx_following_length = i_pwdata[`COUNT_MSB:0];
          next_rx_end              = 1'b0;
        end
        `OFF_TX_FOLLOWING_ADDRESS: next_tx_following_address = i_pwdata;
        `OFF_TX_FOLLOWING_LENGTH: begin
          next_tx_following_length = i_pwdata[`COUNT_MSB:0];
          next_tx_end              = 1'b0;
        end
        `OFF_ENABLE_COMMAND: begin
          if (i_pwdata[`BIT_RX_DISABLE]) begin
            next_rx_enabled = 1'b0;
          end else if (i_pwdata[`BIT_RX_ENABLE]) begin
            next_rx_enabled = 1'b1;
          end
          if (i_pwdata[`BIT_TX_DISABLE]) begin
            next_tx_enabled = 1'b0;
          end else if (i_pwdata[`BIT_TX_ENABLE]) begin
            next_tx_enabled = 1'b1;
          end
        end
        // Status and unmapped offsets were refused at the take edge; nothing changes
        default: begin
        end
      endcase
    end

    // A buffer end that meets a count write in one cycle still sets the flag,
    // so software never misses an end that really happened
    if (rx_last) begin
      next_rx_end = 1'b1;
    end
    if (tx_last) begin
      next_tx_end = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rx_buffer_address    <= `RESET_WORD;
      rx_transfers_left    <= `RESET_COUNT;
      tx_buffer_address    <= `RESET_WORD;
      tx_transfers_left    <= `RESET_COUNT;
      rx_following_address <= `RESET_WORD;
      rx_following_length  <= `RESET_COUNT;
      tx_following_address <= `RESET_WORD;
      tx_following_length  <= `RESET_COUNT;
      rx_enabled           <= 1'b0;
      tx_enabled           <= 1'b0;
      rx_end               <= 1'b0;
      tx_end               <= 1'b0;
    end else begin
      rx_buffer_address    <= next_rx_buffer_address;
      rx_transfers_left    <= next_rx_transfers_left;
      tx_buffer_address    <= next_tx_buffer_address;
      tx_transfers_left    <= next_tx_transfers_left;
      rx_following_address <= next_rx_following_address;
      rx_following_length  <= next_rx_following_length;
      tx_following_address <= next_tx_following_address;
      tx_following_length  <= next_tx_following_length;
      rx_enabled           <= next_rx_enabled;
      tx_enabled           <= next_tx_enabled;
      rx_end               <= next_rx_end;
      tx_end               <= next_tx_end;
    end
  end

  // ==========================================================
  // Outputs
  // Both-buffers flags are registered one cycle behind the counts to keep outputs flop-driven
  logic rx_full_flag, next_rx_full_flag;
  logic tx_empty_flag, next_tx_empty_flag;
  always_comb begin
    next_rx_full_flag  = rx_transfers_left == `RESET_COUNT && rx_following_length == `RESET_COUNT;
    next_tx_empty_flag = tx_transfers_left == `RESET_COUNT && tx_following_length == `RESET_COUNT;
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rx_full_flag  <= 1'b0;
      tx_empty_flag <= 1'b0;
    end else begin
      rx_full_flag  <= next_rx_full_flag;
      tx_empty_flag <= next_tx_empty_flag;
    end
  end

  assign o_prdata                    = prdata;
  assign o_pready                    = pready;
  assign o_pslverr                   = pslverr;
  assign o_mem_req                   = mem_req;
  assign o_mem_write                 = mem_write;
  assign o_mem_addr                  = mem_addr;
  assign o_rx_buffer_end_flag        = rx_end;
  assign o_tx_buffer_end_flag        = tx_end;
  assign o_rx_all_buffers_full_flag  = rx_full_flag;
  assign o_tx_all_buffers_empty_flag = tx_empty_flag;

endmodule // peripheral_dma
`default_nettype wire

// File: rtl/peripheral_dma_defines.svh
// Register offsets, field positions and reset values of the peripheral DMA channel pair.
// Assumes inclusion by bare name from the design file.
`ifndef PERIPHERAL_DMA_DEFINES_SVH
`define PERIPHERAL_DMA_DEFINES_SVH
// ==========================================================
// Register byte offsets
`define OFF_RX_BUFFER_ADDRESS    12'h100
`define OFF_RX_TRANSFERS_LEFT    12'h104
`define OFF_TX_BUFFER_ADDRESS    12'h108
`define OFF_TX_TRANSFERS_LEFT    12'h10C
`define OFF_RX_FOLLOWING_ADDRESS 12'h110
`define OFF_RX_FOLLOWING_LENGTH  12'h114
`define OFF_TX_FOLLOWING_ADDRESS 12'h118
`define OFF_TX_FOLLOWING_LENGTH  12'h11C
`define OFF_ENABLE_COMMAND       12'h120
`define OFF_ENABLE_STATE         12'h124
// ==========================================================
// Field positions
`define BIT_RX_ENABLE            0
`define BIT_RX_DISABLE           1
`define BIT_TX_ENABLE            8
`define BIT_TX_DISABLE           9
`define COUNT_MSB                15
`define ADDR_MSB                 11
// ==========================================================
// Values
`define RESET_WORD               32'h0000_0000
`define RESET_COUNT              16'h0000
`define COUNT_ONE                16'h0001
`define STEP_BYTE                32'h0000_0001
`define STEP_HALF                32'h0000_0002
`define STEP_WORD                32'h0000_0004
`define SIZE_BYTE                2'h0
`define SIZE_HALF                2'h1
`endif

// File: rtl/peripheral_dma_pkg.sv
// Types shared by the peripheral DMA channel pair.
// Assumes nothing of its surroundings.
`default_nettype none
package peripheral_dma_pkg;
  typedef enum logic [1:0] {
    MOVE_IDLE = 2'b00,
    MOVE_RX   = 2'b01,
    MOVE_TX   = 2'b10
  } move_state_e;
endpackage
`default_nettype wire

// File: verification/peripheral_dma_assertions.sv
// Concurrent checks on the APB and memory-move ports of the DMA channel pair.
// Assumes it is bound to peripheral_dma and sees only its ports.
`default_nettype none
module peripheral_dma_assertions (
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        i_rx_ready,
  input wire logic        o_mem_req,
  input wire logic        o_mem_write,
  input wire logic [31:0] o_mem_addr,
  input wire logic        i_mem_done
);
  // ==========================================================
  // Checks
  wire logic take = i_psel && i_penable && !o_pready;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  answer_follows_a: assert property (take |=> o_pready) else $error("access not answered");
  single_pulse_a: assert property (o_pready |=> !o_pready) else $error("ready longer than one cycle");
  err_with_ready_a: assert property (o_pslverr |-> o_pready) else $error("error without ready");
  idle_rdata_a: assert property (!o_pready |-> o_prdata == 32'h0) else $error("read data outside answer");
  status_locked_a: assert property (take && i_pwrite && i_paddr == 12'h124 |=> o_pslverr)
    else $error("status write accepted");
  command_unread_a: assert property (take && !i_pwrite && i_paddr == 12'h120 |=> o_prdata == 32'h0 && !o_pslverr)
    else $error("command register readable");
  below_map_a: assert property (take && i_paddr < 12'h100 |=> o_pslverr) else $error("unmapped access accepted");
  move_hold_a: assert property (o_mem_req && !i_mem_done |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_write))
    else $error("move changed before done");
  move_end_a: assert property (o_mem_req && i_mem_done |=> !o_mem_req) else $error("move kept after done");
  rx_cause_a: assert property ($rose(o_mem_req) && o_mem_write |-> $past(i_rx_ready))
    else $error("receive move without ready");
endmodule // peripheral_dma_assertions

bind peripheral_dma peripheral_dma_assertions chk (.i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_rx_ready(i_rx_ready), .o_mem_req(o_mem_req), .o_mem_write(o_mem_write),
  .o_mem_addr(o_mem_addr), .i_mem_done(i_mem_done));
`default_nettype wire

// File: verification/peripheral_dma_far_side.sv
// Memory side model: answers each move with a one-cycle done after a set wait.
// Assumes the move request stays up until done is seen.
`default_nettype none
module peripheral_dma_far_side (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_mem_req,
  input  wire logic [3:0] i_wait,
  output var  logic       o_mem_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] held;
  // Done is never repeated while the request is still falling
  always @(posedge i_clk) begin
    if (i_reset) begin
      held       <= 4'h0;
      o_mem_done <= 1'b0;
    end else begin
      o_mem_done <= i_mem_req && !o_mem_done && held >= i_wait;
      held       <= (i_mem_req && !o_mem_done) ? held + 4'h1 : 4'h0;
    end
  end
endmodule // peripheral_dma_far_side
`default_nettype wire

// File: verification/tb_peripheral_dma.sv
// Self-checking bench for the DMA channel pair: register access and chained moves.
// Assumes the far-side model for memory; the bench drives the peripheral ready levels.
`default_nettype none
module tb_peripheral_dma import peripheral_dma_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, maddr, rd;
  logic [1:0]  size = 2'h0;
  logic [3:0]  lat = 4'h0;
  logic        rxr = 1'b0, txr = 1'b0, req_d = 1'b0;
  logic        pready, pslverr, req, mw, done, rxe, txe, rxf, txf, er;
  logic [32:0] moves[$];
  int          errors = 0;
  int          cmp_count = 0;
  localparam logic [31:0] cmd_seq [7]   = '{32'h001, 32'h003, 32'h100, 32'h000, 32'h300, 32'h101, 32'h202};
  localparam logic [31:0] state_seq [7] = '{32'h001, 32'h000, 32'h100, 32'h100, 32'h000, 32'h101, 32'h000};
  always #50 clk = ~clk;
  peripheral_dma dut (.i_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_transfer_size(size), .i_rx_ready(rxr), .i_tx_ready(txr), .o_mem_req(req), .o_mem_write(mw),
    .o_mem_addr(maddr), .i_mem_done(done), .o_rx_buffer_end_flag(rxe), .o_tx_buffer_end_flag(txe),
    .o_rx_all_buffers_full_flag(rxf), .o_tx_all_buffers_empty_flag(txf));
  peripheral_dma_far_side far (.i_clk(clk), .i_reset(rst), .i_mem_req(req), .i_wait(lat), .o_mem_done(done));
  // ==========================================================
  // Move log, one entry per started move
  always @(posedge clk) begin
    req_d <= req;
    if (req === 1'b1 && req_d === 1'b0) moves.push_back({mw, maddr});
  end
  // ==========================================================
  // Tasks
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 20) begin
      errors++;
      $display("[FAIL] %0t bus timeout", $time);
      close_out();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(33'(rd), 33'(e));
  endtask
  // Waits until k moves have started and the mover is idle again
  task automatic await_moves(input int k);
    int n;
    for (n = 0; n < 300 && !(moves.size() == k && req === 1'b0 && req_d === 1'b0); n++) @(posedge clk);
    if (n >= 300) begin
      errors++;
      $display("[FAIL] %0t move timeout", $time);
      close_out();
    end
  endtask
  // ==========================================================
  // Tests
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) rdc(12'h100 + 12'(4 * i), 32'h0);
    $display("reset values done");
    for (int i = 0; i < 8; i++) wr(12'h100 + 12'(4 * i), 32'hA5C3_96E0 + 32'(i));
    for (int i = 0; i < 8; i++) rdc(12'h100 + 12'(4 * i), (32'hA5C3_96E0 + 32'(i)) & (i % 2 ? 32'h0000_FFFF : 32'hFFFF_FFFF));
    wr(12'h124, 32'h0000_0101);
    check(33'(er), 33'h1);
    rdc(12'h124, 32'h0);
    bus(1'b0, 12'h0FC, 32'h0);
    check(33'(er), 33'h1);
    $display("register access done");
    for (int i = 0; i < 7; i++) begin
      wr(12'h120, cmd_seq[i]);
      rdc(12'h124, state_seq[i]);
    end
    $display("enable commands done");
    size <= 2'h1;
    wr(12'h100, 32'h0000_1000);
    wr(12'h104, 32'h0000_0002);
    wr(12'h110, 32'h0000_2000);
    wr(12'h114, 32'h0000_0001);
    wr(12'h120, 32'h0000_0001);
    rxr <= 1'b1;
    await_moves(3);
    rxr <= 1'b0;
    check(moves[0], 33'h1_0000_1000);
    check(moves[1], 33'h1_0000_1002);
    check(moves[2], 33'h1_0000_2000);
    rdc(12'h100, 32'h0000_2000);
    rdc(12'h104, 32'h0);
    rdc(12'h114, 32'h0);
    check(33'(rxe), 33'h1);
    check(33'(rxf), 33'h1);
    wr(12'h114, 32'h0);
    @(posedge clk);
    check(33'(rxe), 33'h0);
    $display("receive chain done");
    size <= 2'h2;
    lat <= 4'h3;
    wr(12'h108, 32'h0000_3000);
    wr(12'h10C, 32'h0000_0002);
    wr(12'h118, 32'h0000_4000);
    wr(12'h11C, 32'h0);
    wr(12'h120, 32'h0000_0100);
    txr <= 1'b1;
    await_moves(5);
    check(moves[3], 33'h0_0000_3000);
    check(moves[4], 33'h0_0000_3004);
    rdc(12'h108, 32'h0000_4000);
    rdc(12'h10C, 32'h0);
    check(33'(txe), 33'h1);
    wr(12'h120, 32'h0000_0100);
    rdc(12'h124, 32'h0000_0100);
    check(33'(moves.size()), 33'd5);
    txr <= 1'b0;
    wr(12'h10C, 32'h0);
    @(posedge clk);
    check(33'(txe), 33'h0);
    $display("transmit chain done");
    size <= 2'h0;
    lat <= 4'h0;
    wr(12'h100, 32'h0000_5000);
    wr(12'h104, 32'h0000_0002);
    wr(12'h120, 32'h0000_0001);
    rxr <= 1'b1;
    await_moves(7);
    rxr <= 1'b0;
    check(moves[5], 33'h1_0000_5000);
    check(moves[6], 33'h1_0000_5001);
    $display("byte step done");
    close_out();
  end
endmodule // tb_peripheral_dma
`default_nettype wire
